// ==== lcdcp_regs.vh ====
// Operation
// RL1: Host holds reset low at least 1 us
// RL2: Commands accepted 1 us after reset release
// RL3: Hardware reset clears all registers; read path (data_out, data_oe_n, rd_latch_ff) clears on rst only
// RL4: Reset command clears only listed registers
// RL5: Voltage command loads register; resets clear it
// RL6: Commands execute on internal clock, fast
// RL7: Intel mode: low read or write strobes
// RL8: Motorola mode: rw select, high enable
// RL9: Serial bytes arrive most significant first
// RL10: 1010111D switches display on or off
// RL11: 01 plus six bits loads start line
// RL12: 1011 nibble loads page; page 8 bit0
// RL13: 0001/0000 nibbles load column high/low
// RL14: Status read: flags high, zeros low
// RL15: Data access uses current page and column
// RL16: 1010000D selects segment direction
// RL17: 1010011D inverts; 1010010D lights all
// RL18: 1010100D selects duty; 1010101D adds one
// RL19: 0011 nibble sets line reverse; 00100000 releases
// RL20: Read-modify-write: advance on writes only
// RL21: 1100 nibble loads output status register
// RL22: 0010010D power on/off; 11101101 completes
// RL23: Both resets clear line, column, page
// RL24: Status shows busy, direction, off, reset
// RL25: Column advances after data access, saturating
// RL26: Undefined command bytes are ignored
`ifndef LCDCP_REGS_VH
`define LCDCP_REGS_VH
`define LCDCP_CLK_MHZ      40
`define LCDCP_RST_WAIT_NS  1000
`define LCDCP_RST_CYC      ((`LCDCP_RST_WAIT_NS*`LCDCP_CLK_MHZ+999)/1000)
`define LCDCP_LAST_COL     8'ha6
`define LCDCP_IND_PAGE     4'h8
`define LCDCP_RAM_DEPTH    1512
`define LCDCP_PAGE_COLS    11'd168
`define LCDCP_CMD_DISP     8'hae
`define LCDCP_CMD_ADC      8'ha0
`define LCDCP_CMD_ALLON    8'ha4
`define LCDCP_CMD_REV      8'ha6
`define LCDCP_CMD_DUTY     8'ha8
`define LCDCP_CMD_DUTYP1   8'haa
`define LCDCP_CMD_NLREL    8'h20
`define LCDCP_CMD_PWR      8'h24
`define LCDCP_CMD_RMW      8'he0
`define LCDCP_CMD_END      8'hee
`define LCDCP_CMD_RESET    8'he2
`define LCDCP_CMD_PWRDONE  8'hed
`define LCDCP_MODE_INTEL   2'h0
`define LCDCP_MODE_MOTO    2'h1
`define LCDCP_MODE_SERIAL  2'h2
`endif

// ==== lcdcp_bus_front.v ====
`timescale 1ns/10ps
`include "lcdcp_regs.vh"
// Turns strobes of three bus styles into one-cycle transfer pulses
module lcdcp_bus_front (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire [1:0] bus_mode,
   input  wire       rd_n,
   input  wire       wr_n,
   input  wire       rw_sel,
   input  wire       enable,
   input  wire       ser_clk,
   input  wire       ser_data,
   input  wire       ser_cs_n,
   input  wire [7:0] data_in,
   output reg        wr_pulse,
   output reg        rd_pulse,
   output reg  [7:0] wr_byte
);
   reg       rd_n_ff;     // Previous read strobe
   reg       wr_n_ff;     // Previous write strobe
   reg       en_ff;       // Previous enable
   reg       sclk_ff;     // Previous serial clock
   reg [7:0] sh_ff;       // Serial shift register
   reg [2:0] bit_ff;      // Serial bit count
   wire      sclk_rise;   // Serial sample edge
   wire [7:0] sh_nxt;

   assign sclk_rise = ser_clk & ~sclk_ff & ~ser_cs_n;
   assign sh_nxt = {sh_ff[6:0], ser_data};

   // Parallel transfers fire at strobe release, when data is stable; serial at the eighth clock rise
   always @(posedge ref_clk) begin
      if (rst) begin
         rd_n_ff  <= 1'b1;
         wr_n_ff  <= 1'b1;
         en_ff    <= 1'b0;
         sclk_ff  <= 1'b0;
         sh_ff    <= 8'h00;
         bit_ff   <= 3'h0;
         wr_pulse <= 1'b0;
         rd_pulse <= 1'b0;
         wr_byte  <= 8'h00;
      end else begin
         rd_n_ff  <= rd_n;
         wr_n_ff  <= wr_n;
         en_ff    <= enable;
         sclk_ff  <= ser_clk;
         wr_pulse <= 1'b0;
         rd_pulse <= 1'b0;
         case (bus_mode)
            `LCDCP_MODE_INTEL: begin
               if (rd_n & ~rd_n_ff)
                  rd_pulse <= 1'b1; // RL7
               if (wr_n & ~wr_n_ff) begin
                  wr_pulse <= 1'b1; // RL7
                  wr_byte  <= data_in;
               end
            end
            `LCDCP_MODE_MOTO: begin
               // Falling edge of enable ends the high pulse
               if (~enable & en_ff) begin
                  if (rw_sel)
                     rd_pulse <= 1'b1; // RL8
                  else begin
                     wr_pulse <= 1'b1; // RL8
                     wr_byte  <= data_in;
                  end
               end
            end
            `LCDCP_MODE_SERIAL: begin
               // Reads are not possible over the serial link
               if (ser_cs_n)
                  bit_ff <= 3'h0;
               else if (sclk_rise) begin
                  sh_ff  <= sh_nxt; // RL9
                  bit_ff <= bit_ff + 3'h1;
                  if (bit_ff == 3'h7) begin
                     wr_pulse <= 1'b1;
                     wr_byte  <= sh_nxt;
                  end
               end
            end
            default: begin
               bit_ff <= 3'h0;
            end
         endcase
      end
   end
endmodule

// ==== lcdcp_ram.v ====
`timescale 1ns/10ps
`include "lcdcp_regs.vh"
// Display RAM, one byte per page and column
module lcdcp_ram (
   input  wire        ref_clk,
   input  wire        we,
   input  wire [10:0] addr,
   input  wire [7:0]  wdata,
   output reg  [7:0]  rdata
);
   reg [7:0] mem [0:`LCDCP_RAM_DEPTH-1]; // Page-major storage

   // Synchronous read keeps it a plain block RAM
   always @(posedge ref_clk) begin
      if (we)
         mem[addr] <= wdata;
      rdata <= mem[addr];
   end
endmodule

// ==== lcdcp_top.v ====
`timescale 1ns/10ps
`include "lcdcp_regs.vh"
// Command interpreter of the display driver host port
module lcdcp_top (
   input  wire       ref_clk,
   input  wire       rst,
   input  wire       hw_reset_n,
   input  wire [1:0] bus_mode,
   input  wire       cmd_data_select,
   input  wire       rd_n,
   input  wire       wr_n,
   input  wire       rw_sel,
   input  wire       enable,
   input  wire       ser_clk,
   input  wire       ser_data,
   input  wire       ser_cs_n,
   input  wire [7:0] data_in,
   output reg  [7:0] data_out,
   output reg        data_oe_n,
   output reg        display_on,
   output reg  [5:0] start_line,
   output reg  [3:0] page_addr,
   output reg  [7:0] column_addr,
   output reg        seg_reverse,
   output reg        display_invert,
   output reg        all_points_on,
   output reg        duty_long,
   output reg        duty_plus_one,
   output reg        line_rev_en,
   output reg  [3:0] line_rev_count,
   output reg        rmw_mode,
   output reg  [3:0] output_status,
   output reg        power_on,
   output reg        power_done,
   output reg  [4:0] drive_voltage,
   output reg        busy
);
   localparam integer RST_CYC_I = `LCDCP_RST_CYC; // Cycles in 1 us
   localparam [15:0]  RST_CYC   = RST_CYC_I[15:0];
   localparam [1:0] ST_IDLE = 2'h0; // Waiting for a transfer
   localparam [1:0] ST_RST  = 2'h1; // Reset in progress
   localparam [1:0] ST_READ = 2'h2; // RAM read in flight

   reg  [1:0]  state_ff;       // Sequencer state
   reg  [1:0]  nxt_state;
   reg  [15:0] rcnt_ff;        // Reset hold counter
   reg         rst_active_ff;  // Reset flag for status
   reg  [7:0]  rd_latch_ff;    // Read data buffer for next read
   wire        front_rst;      // Either reset clears the bus front
   wire        wr_pulse;       // One-cycle write transfer
   wire        rd_pulse;       // One-cycle read transfer
   wire [7:0]  wr_byte;        // Written byte
   wire [7:0]  ram_rdata;      // RAM output
   wire        ram_we;         // RAM write enable
   wire [10:0] ram_addr;       // Page and column address
   wire [7:0]  ram_wdata;      // Masked write data
   wire        soft_rst;       // Reset command seen
   wire        cmd_wr;         // Command byte write
   wire        dat_wr;         // Data byte write
   wire        dat_rd;         // Data byte read

   // Column advance saturates at the last column
   function [7:0] col_inc;
      input [7:0] c;
      begin
         if (c >= `LCDCP_LAST_COL)
            col_inc = c; // Holds, never steps back
         else
            col_inc = c + 8'h01;
      end
   endfunction

   // Device reset also clears the serial shift register
   assign front_rst = rst | ~hw_reset_n; // RL3

   lcdcp_bus_front u_front (
      .ref_clk  (ref_clk),
      .rst      (front_rst),
      .bus_mode (bus_mode),
      .rd_n     (rd_n),
      .wr_n     (wr_n),
      .rw_sel   (rw_sel),
      .enable   (enable),
      .ser_clk  (ser_clk),
      .ser_data (ser_data),
      .ser_cs_n (ser_cs_n),
      .data_in  (data_in),
      .wr_pulse (wr_pulse),
      .rd_pulse (rd_pulse),
      .wr_byte  (wr_byte)
   );

   // Page major address: page times columns plus column
   assign ram_addr = ({7'h00, page_addr} * `LCDCP_PAGE_COLS) +
                     {3'h0, column_addr};
   assign cmd_wr = wr_pulse & ~cmd_data_select & (state_ff == ST_IDLE);
   assign dat_wr = wr_pulse & cmd_data_select & (state_ff == ST_IDLE);
   assign dat_rd = rd_pulse & cmd_data_select & (state_ff == ST_IDLE);
   assign ram_we = dat_wr; // RL15
   // Indicator page keeps only the lowest bit
   assign ram_wdata = (page_addr == `LCDCP_IND_PAGE) ?
                      {7'h00, wr_byte[0]} : wr_byte; // RL12
   assign soft_rst = cmd_wr & (wr_byte == `LCDCP_CMD_RESET);

   lcdcp_ram u_ram (
      .ref_clk (ref_clk),
      .we      (ram_we),
      .addr    (ram_addr),
      .wdata   (ram_wdata),
      .rdata   (ram_rdata)
   );

   // Next state of the sequencer
   always @* begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: begin
            if (soft_rst)
               nxt_state = ST_RST;
            else if (dat_rd)
               nxt_state = ST_READ;
         end
         ST_RST: begin
            if (rcnt_ff == RST_CYC)
               nxt_state = ST_IDLE; // RL2
         end
         ST_READ:
            nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   // Sequencer, reset timing and busy flag
   always @(posedge ref_clk) begin
      if (rst | ~hw_reset_n) begin
         state_ff      <= ST_RST; // RL3
         rcnt_ff       <= 16'h0000;
         rst_active_ff <= 1'b1;
         busy          <= 1'b1;
      end else begin
         state_ff <= nxt_state;
         if (state_ff == ST_RST)
            rcnt_ff <= rcnt_ff + 16'h0001;
         else
            rcnt_ff <= 16'h0000;
         rst_active_ff <= (nxt_state == ST_RST);
         busy <= (nxt_state != ST_IDLE); // RL24 RL6
      end
   end

   // Command decode into settings
   always @(posedge ref_clk) begin
      if (rst | ~hw_reset_n) begin
         // Full clear on hardware reset
         display_on     <= 1'b0; // RL3
         seg_reverse    <= 1'b0;
         display_invert <= 1'b0;
         all_points_on  <= 1'b0;
         duty_long      <= 1'b0;
         duty_plus_one  <= 1'b0;
         rmw_mode       <= 1'b0;
         power_on       <= 1'b0;
         power_done     <= 1'b0;
         start_line     <= 6'h00; // RL23
         column_addr    <= 8'h00;
         page_addr      <= 4'h0;
         output_status  <= 4'h0;
         line_rev_en    <= 1'b0;
         line_rev_count <= 4'h0;
         drive_voltage  <= 5'h00; // RL5
      end else if (soft_rst) begin
         // Reset command leaves mode bits alone
         start_line     <= 6'h00; // RL4 RL23
         column_addr    <= 8'h00;
         page_addr      <= 4'h0;
         output_status  <= 4'h0;
         // Line reverse enable survives; only its count clears
         line_rev_count <= 4'h0;
         drive_voltage  <= 5'h00; // RL5
      end else if (cmd_wr) begin
         if (wr_byte[7:6] == 2'b01)
            start_line <= wr_byte[5:0]; // RL11
         else if (wr_byte[7:4] == 4'hb) begin
            // Pages above the indicator page are ignored
            if (wr_byte[3:0] <= `LCDCP_IND_PAGE)
               page_addr <= wr_byte[3:0]; // RL12
         end else if (wr_byte[7:4] == 4'h1)
            column_addr[7:4] <= wr_byte[3:0]; // RL13
         else if (wr_byte[7:4] == 4'h0)
            column_addr[3:0] <= wr_byte[3:0]; // RL13
         else if (wr_byte[7:4] == 4'h3) begin
            line_rev_en    <= 1'b1; // RL19
            line_rev_count <= wr_byte[3:0];
         end else if (wr_byte[7:4] == 4'hc)
            output_status <= wr_byte[3:0]; // RL21
         else if (wr_byte[7:5] == 3'b100)
            drive_voltage <= wr_byte[4:0]; // RL5
         else begin
            case (wr_byte)
               `LCDCP_CMD_DISP, `LCDCP_CMD_DISP | 8'h01:
                  display_on <= wr_byte[0]; // RL10
               `LCDCP_CMD_ADC, `LCDCP_CMD_ADC | 8'h01:
                  seg_reverse <= wr_byte[0]; // RL16
               `LCDCP_CMD_REV, `LCDCP_CMD_REV | 8'h01:
                  display_invert <= wr_byte[0]; // RL17
               `LCDCP_CMD_ALLON, `LCDCP_CMD_ALLON | 8'h01:
                  all_points_on <= wr_byte[0]; // RL17
               `LCDCP_CMD_DUTY, `LCDCP_CMD_DUTY | 8'h01:
                  duty_long <= wr_byte[0]; // RL18
               `LCDCP_CMD_DUTYP1, `LCDCP_CMD_DUTYP1 | 8'h01:
                  duty_plus_one <= wr_byte[0]; // RL18
               `LCDCP_CMD_NLREL:
                  line_rev_en <= 1'b0; // RL19
               `LCDCP_CMD_PWR, `LCDCP_CMD_PWR | 8'h01:
                  power_on <= wr_byte[0]; // RL22
               `LCDCP_CMD_PWRDONE:
                  power_done <= 1'b1; // RL22
               `LCDCP_CMD_RMW:
                  rmw_mode <= 1'b1; // RL20
               `LCDCP_CMD_END:
                  rmw_mode <= 1'b0; // RL20
               default: begin
                  rmw_mode <= rmw_mode; // RL26
               end
            endcase
         end
      end else if (dat_wr) begin
         column_addr <= col_inc(column_addr); // RL25 RL20
      end else if (dat_rd & ~rmw_mode) begin
         column_addr <= col_inc(column_addr); // RL25 RL20
      end
   end

   // Read path: data read returns previous buffered byte
   always @(posedge ref_clk) begin
      if (rst) begin
         data_out    <= 8'h00;
         data_oe_n   <= 1'b1;
         rd_latch_ff <= 8'h00;
      end else begin
         if (state_ff == ST_READ)
            rd_latch_ff <= ram_rdata; // RL15
         if (rd_pulse & ~cmd_data_select) begin
            data_out <= {busy, ~seg_reverse, ~display_on,
                         rst_active_ff, 4'h0}; // RL14 RL24
            data_oe_n <= 1'b0;
         end else if (rd_pulse) begin
            data_out  <= rd_latch_ff; // RL15
            data_oe_n <= 1'b0;
         end else if (wr_pulse)
            data_oe_n <= 1'b1;
      end
   end
endmodule

// ==== lcdcp_host.sv ====
`timescale 1ns/10ps
// Host microprocessor on the parallel or serial port
module lcdcp_host (
   input  logic       ref_clk,
   input  logic       busy,
   output logic [1:0] bus_mode,
   output logic       cmd_data_select,
   output logic       rd_n,
   output logic       wr_n,
   output logic       rw_sel,
   output logic       enable,
   output logic       ser_clk,
   output logic       ser_data,
   output logic       ser_cs_n,
   output logic [7:0] data_in
);
   // Idle bus at time zero, serial clock parked high
   initial begin
      bus_mode = 2'h0;
      cmd_data_select = 1'b0;
      {rd_n, wr_n, rw_sel, enable} = 4'hc;
      {ser_clk, ser_data, ser_cs_n} = 3'h5;
      data_in = 8'h00;
   end
   // Waits, bounded, until the device takes requests again
   task automatic idle();
      int i;
      for (i = 0; i < 100 && busy !== 1'b0; i++) begin
         @(posedge ref_clk);
         #2;
      end
   endtask
   // One transfer; lines held until the edge that samples release
   task automatic xfer(input logic [1:0] m, input logic a0,
                       input logic rd, input logic [7:0] d);
      int i;
      @(posedge ref_clk);
      #2;
      bus_mode = m;
      cmd_data_select = a0;
      data_in = d;
      rw_sel = rd;
      @(posedge ref_clk);
      #2;
      if (m == 2'h2) begin
         ser_cs_n = 1'b0;
         for (i = 7; i >= 0; i--) begin
            ser_clk = 1'b0;
            ser_data = d[i];
            @(posedge ref_clk);
            #2;
            ser_clk = 1'b1;
            @(posedge ref_clk);
            #2;
         end
      end else begin
         enable = (m == 2'h1);
         rd_n = !(m == 2'h0 && rd);
         wr_n = !(m == 2'h0 && !rd);
         @(posedge ref_clk);
         #2;
         {rd_n, wr_n, enable} = 3'h6;
         @(posedge ref_clk);
         #2;
      end
      // Released lines show inverted data, not the last value
      ser_cs_n = 1'b1;
      ser_data = !ser_data;
      data_in = ~d;
      repeat (4) @(posedge ref_clk);
      #2;
      idle();
   endtask
endmodule

// ==== lcdcp_asserts.sv ====
`timescale 1ns/10ps
// Timing relations at the host port
module lcdcp_asserts (
   input logic       ref_clk,
   input logic       rst,
   input logic       hw_reset_n,
   input logic [1:0] bus_mode,
   input logic       cmd_data_select,
   input logic       rd_n,
   input logic       wr_n,
   input logic       rw_sel,
   input logic       enable,
   input logic       ser_cs_n,
   input logic [7:0] data_in,
   input logic [7:0] data_out,
   input logic       data_oe_n,
   input logic       display_on,
   input logic [3:0] page_addr,
   input logic [7:0] column_addr,
   input logic       seg_reverse,
   input logic       rmw_mode,
   input logic [4:0] drive_voltage,
   input logic       busy
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   logic [3:0] idle_ff;  // Quiet bus cycles, saturating
   // Settings may only move shortly after a transfer
   always @(posedge ref_clk) begin
      if (rst || !(rd_n && wr_n && !enable && ser_cs_n))
         idle_ff <= 4'h0;
      else if (idle_ff != 4'hf)
         idle_ff <= idle_ff + 4'h1;
   end
   sequence s_iwr;  // Accepted write strobe release
      $rose(wr_n) && bus_mode == 2'h0 && !busy;
   endsequence
   sequence s_ird;  // Accepted read strobe release
      $rose(rd_n) && bus_mode == 2'h0 && !busy;
   endsequence
   AST_BUSY_RST: assert property ($fell(rst) && hw_reset_n
      |-> busy [*8]) else $error("busy low right after reset");
   AST_HW_CLEAR: assert property (!hw_reset_n |=> !display_on && !rmw_mode
      && page_addr == 4'h0 && column_addr == 8'h00 && drive_voltage == 5'h0)
      else $error("settings kept through device reset");
   AST_BUSY_END: assert property (disable iff (rst || !hw_reset_n)
      $rose(busy) |-> ##[1:60] !busy) else $error("busy too long");
   AST_QUIET: assert property (idle_ff >= 4'h4 && hw_reset_n
      && $past(hw_reset_n) |-> $stable({display_on, seg_reverse,
      page_addr, column_addr, drive_voltage}))
      else $error("setting moved with no transfer");
   AST_STATUS: assert property (s_ird ##0 !cmd_data_select |-> ##2
      !data_oe_n && data_out == {1'b0, !seg_reverse, !display_on, 5'h0})
      else $error("status byte wrong");
   AST_COL_STEP: assert property (s_iwr ##0 cmd_data_select
      && column_addr < 8'ha6 |-> ##2 column_addr ==
      $past(column_addr, 2) + 8'h01) else $error("column not stepped");
   AST_RMW_HOLD: assert property (s_ird ##0 cmd_data_select && rmw_mode
      |-> ##2 column_addr == $past(column_addr, 2))
      else $error("column moved on read");
   AST_DISP: assert property (s_iwr ##0 !cmd_data_select
      && data_in[7:1] == 7'h57 |-> ##2 $past(data_in, 2) ==
      {7'h57, display_on}) else $error("display switch wrong");
   AST_VOLT: assert property (s_iwr ##0 !cmd_data_select
      && data_in[7:5] == 3'h4 |-> ##2 $past(data_in, 2) ==
      {3'h4, drive_voltage}) else $error("voltage load wrong");
   AST_MPAGE: assert property ($fell(enable) && bus_mode == 2'h1
      && !rw_sel && !busy && !cmd_data_select && data_in[7:4] == 4'hb
      && data_in[3:0] <= 4'h8 |-> ##2 $past(data_in, 2) ==
      {4'hb, page_addr}) else $error("page load wrong");
endmodule
bind lcdcp_top lcdcp_asserts chk (.ref_clk(ref_clk), .rst(rst),
   .hw_reset_n(hw_reset_n), .bus_mode(bus_mode),
   .cmd_data_select(cmd_data_select), .rd_n(rd_n), .wr_n(wr_n),
   .rw_sel(rw_sel), .enable(enable), .ser_cs_n(ser_cs_n),
   .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
   .display_on(display_on), .page_addr(page_addr),
   .column_addr(column_addr), .seg_reverse(seg_reverse),
   .rmw_mode(rmw_mode), .drive_voltage(drive_voltage), .busy(busy));

// ==== lcdcp_top_tb.sv ====
`timescale 1ns/10ps
// Listed and random commands over all three bus styles
module lcdcp_top_tb;
   logic        ref_clk = 1'b0;
   logic        rst = 1'b1;
   logic        hw_reset_n = 1'b1;
   wire  [1:0]  bus_mode;
   wire         cmd_data_select, rd_n, wr_n, rw_sel, enable, busy;
   wire         ser_clk, ser_data, ser_cs_n, data_oe_n;
   wire  [7:0]  data_in, data_out;
   wire  [40:0] sv;        // All setting outputs, packed
   logic [40:0] ex;        // Expected settings
   logic [41:0] notes[$];  // Kind bit, then expected value
   logic [41:0] nt;
   logic [7:0]  mem[int];  // Display RAM cells written so far
   logic [7:0]  buf_v;     // Byte the next data read returns
   logic        buf_ok = 1'b0;
   logic [31:0] seed = 32'hbe61cde6;
   int          mismatches = 0, compares = 0, cycles = 0;
   event        settle_ev;
   logic [7:0]  cmds[34] = '{8'hae, 8'haf, 8'h40, 8'h7f, 8'hb3, 8'hb8,
      8'hb9, 8'h1a, 8'h03, 8'ha1, 8'ha0, 8'ha7, 8'ha6, 8'ha5, 8'ha4, 8'ha9,
      8'ha8, 8'hab, 8'haa, 8'h3f, 8'h20, 8'he0, 8'hee, 8'hc9, 8'h25, 8'h24,
      8'hed, 8'h9f, 8'h80, 8'he2, 8'hf0, 8'ha2, 8'h21, 8'hd5};
   // Saturation, read-back, read-modify-write and indicator page
   logic [9:0]  dseq[18] = '{10'h0b2, 10'h01a, 10'h005, 10'h23c, 10'h2c3,
      10'h25a, 10'h005, 10'h300, 10'h300, 10'h300, 10'h0e0, 10'h005,
      10'h300, 10'h300, 10'h0ee, 10'h0b8, 10'h2ff, 10'h300};
   always #12.5 ref_clk = ~ref_clk;
   lcdcp_top uut (.ref_clk(ref_clk), .rst(rst), .hw_reset_n(hw_reset_n),
      .bus_mode(bus_mode), .cmd_data_select(cmd_data_select),
      .rd_n(rd_n), .wr_n(wr_n), .rw_sel(rw_sel), .enable(enable),
      .ser_clk(ser_clk), .ser_data(ser_data), .ser_cs_n(ser_cs_n),
      .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
      .display_on(sv[40]), .start_line(sv[39:34]), .page_addr(sv[33:30]),
      .column_addr(sv[29:22]), .seg_reverse(sv[21]),
      .display_invert(sv[20]), .all_points_on(sv[19]), .duty_long(sv[18]),
      .duty_plus_one(sv[17]), .line_rev_en(sv[16]),
      .line_rev_count(sv[15:12]), .rmw_mode(sv[11]),
      .output_status(sv[10:7]), .power_on(sv[6]), .power_done(sv[5]),
      .drive_voltage(sv[4:0]), .busy(busy));
   lcdcp_host host (.ref_clk(ref_clk), .busy(busy), .bus_mode(bus_mode),
      .cmd_data_select(cmd_data_select), .rd_n(rd_n), .wr_n(wr_n),
      .rw_sel(rw_sel), .enable(enable), .ser_clk(ser_clk),
      .ser_data(ser_data), .ser_cs_n(ser_cs_n), .data_in(data_in));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   // Expected effect of one command byte
   task automatic apply_cmd(input logic [7:0] c);
      casez (c)
         8'b01??????: ex[39:34] = c[5:0];
         8'b1011????: if (c[3:0] <= 4'h8) ex[33:30] = c[3:0];
         8'b0001????: ex[29:26] = c[3:0];
         8'b0000????: ex[25:22] = c[3:0];
         8'b1010111?: ex[40] = c[0];
         8'b1010000?: ex[21] = c[0];
         8'b1010011?: ex[20] = c[0];
         8'b1010010?: ex[19] = c[0];
         8'b1010100?: ex[18] = c[0];
         8'b1010101?: ex[17] = c[0];
         8'b0011????: ex[16:12] = {1'b1, c[3:0]};
         8'h20: ex[16] = 1'b0;
         8'he0: ex[11] = 1'b1;
         8'hee: ex[11] = 1'b0;
         8'he2: ex = ex & 41'h1_0000_3f_0860;
         8'b1100????: ex[10:7] = c[3:0];
         8'b0010010?: ex[6] = c[0];
         8'hed: ex[5] = 1'b1;
         8'b100?????: ex[4:0] = c[4:0];
         default: ;
      endcase
   endtask
   task automatic cmp_set(input logic [40:0] e);
      compares++;
      if (sv !== e) begin
         mismatches++;
         $display("mismatch at %0t: settings %h, expected %h", $time, sv, e);
      end
   endtask
   task automatic cmp_rd(input logic [7:0] e);
      compares++;
      if (data_out !== e) begin
         mismatches++;
         $display("mismatch at %0t: data %h, want %h", $time, data_out, e);
      end
   endtask
   task automatic settle();
      notes.push_back({1'b0, ex});
      -> settle_ev;
   endtask
   // Drives one transfer, then notes what it should have done
   task automatic op(input logic [1:0] m, input logic a0,
                     input logic rd, input logic [7:0] d);
      int key;
      host.xfer(m, a0, rd, d);
      key = {20'h0, ex[33:30], ex[29:22]};
      if (!a0 && rd) begin
         notes.push_back({1'b1, 33'h0, 1'b0, !ex[21], !ex[40], 5'h0});
      end else if (!a0) begin
         apply_cmd(d);
      end else if (!rd) begin
         mem[key] = (ex[33:30] == 4'h8) ? {7'h0, d[0]} : d;
         if (ex[29:22] < 8'ha6) ex[29:22] = ex[29:22] + 8'h01;
      end else begin
         if (buf_ok) notes.push_back({1'b1, 33'h0, buf_v});
         buf_ok = mem.exists(key);
         if (buf_ok) buf_v = mem[key];
         if (!ex[11] && ex[29:22] < 8'ha6)
            ex[29:22] = ex[29:22] + 8'h01;
      end
      settle();
   endtask
   // Takes notes off oldest first as results settle
   always @(settle_ev) begin
      while (notes.size() > 0) begin
         nt = notes.pop_front();
         if (nt[41]) cmp_rd(nt[7:0]);
         else cmp_set(nt[40:0]);
      end
   end
   task automatic print_verdict();
      if (mismatches == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Hang guard, far above the expected run length
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         print_verdict();
      end
   end
   initial begin
      int i;
      logic [7:0] d;
      ex = 41'h0;
      repeat (16) @(posedge ref_clk);
      #2;
      rst = 1'b0;
      host.idle();
      settle();
      for (i = 0; i < 102; i++) op(2'(i % 3), 1'b0, 1'b0, cmds[i / 3]);
      for (i = 0; i < 18; i++) op(2'h0, dseq[i][9], dseq[i][8], dseq[i][7:0]);
      for (i = 0; i < 300; i++) begin
         if (i == 150) begin
            hw_reset_n = 1'b0;
            repeat (40) @(posedge ref_clk);
            #2;
            hw_reset_n = 1'b1;
            ex = 41'h0;
            buf_ok = 1'b0;
            host.idle();
            settle();
         end
         seed = xs(seed);
         d = (seed[7:6] == 2'h0) ? {3'h0, seed[12:8]} : seed[15:8];
         if (d[7:4] == 4'h1 && d[3:0] > 4'h9) d[3:0] = 4'h9;
         // Keeps a low nibble load from leaving the RAM row
         if (d[7:4] == 4'h0 && ex[29:26] == 4'ha && d[3:0] > 4'h6)
            d[3:0] = 4'h6;
         op((seed[1:0] == 2'h3) ? 2'h0 : seed[1:0], seed[4],
            seed[5] && seed[1:0] != 2'h2, d);
      end
      print_verdict();
   end
endmodule
